// File: verilog/dbg_serial_pkg.sv
package dbg_serial_pkg;

   // shift register and frame geometry
   localparam int SHIFT_WIDTH     = 35;
   localparam int CPU_WORD_WIDTH  = 32;
   localparam int TRAP_DATA_WIDTH = 7;
   localparam int CPU_FRAME_BITS  = 35;
   localparam int TRAP_FRAME_BITS = 10;
   localparam int COUNT_WIDTH     = 6;

   // field positions inside the received frame
   localparam int CPU_LEN_POS      = 33;
   localparam int CPU_CTRL_POS     = 32;
   localparam int TRAP_LEN_POS     = 8;
   localparam int TRAP_CTRL_POS    = 7;
   localparam int BRK_NONMASK_POS  = 6;
   localparam int BRK_MASK_POS     = 5;

   // number of exception sources gated by the debug enable mask
   localparam int EXC_SOURCES = 3;

   // reset values
   localparam logic [SHIFT_WIDTH-1:0]     SHIFT_RESET = 35'h7FFFFFFFF;
   localparam logic [TRAP_DATA_WIDTH-1:0] TRAP_RESET  = 7'h00;

   // output status encodings
   typedef enum logic [1:0] {
      STATUS_VALID_DATA = 2'b00,
      STATUS_SEQ_ERROR  = 2'b01,
      STATUS_CPU_EXC    = 2'b10,
      STATUS_NULL       = 2'b11
   } status_type;

   // frame handling states
   typedef enum logic [1:0] {
      ST_READY   = 2'b00,
      ST_SHIFT   = 2'b01,
      ST_DONE    = 2'b10,
      ST_WAITCPU = 2'b11
   } state_type;

   // word handed from the port to the cpu
   typedef struct packed {
      logic                      valid;
      logic                      is_data;
      logic [CPU_WORD_WIDTH-1:0] word;
   } cpu_word_type;

   // trap enable and breakpoint outputs
   typedef struct packed {
      logic [TRAP_DATA_WIDTH-1:0] trap_enables;
      logic                       brk_nonmask;
      logic                       brk_mask;
   } trap_ctrl_type;

endpackage : dbg_serial_pkg

// File: verilog/sync_two_stage.sv
`timescale 1ns/1ns
`default_nettype none
module sync_two_stage #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;   // first stage, read only by the second

   // refuse an empty bus
   if (WIDTH < 1) begin : g_width_check
      $error("sync_two_stage: WIDTH must be at least 1");
   end

   // two flip-flops in series
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         sync_out   <= '0;
      end else begin
         stage1_reg <= async_in;
         sync_out   <= stage1_reg;
      end
   end

endmodule : sync_two_stage
`default_nettype wire

// File: verilog/dbg_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module dbg_serial_port (
   // clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   // serial pins from the development tool
   input  wire logic                                   serial_clock_in,
   input  wire logic                                   serial_data_in,
   // serial pin to the development tool
   output var  logic                                   serial_data_out,
   // general output use of the serial out pin
   input  wire logic                                   gp_out_enable,
   input  wire logic                                   gp_out_level,
   // cpu state and requests
   input  wire logic                                   debug_mode,
   input  wire logic                                   cpu_fetch_pending,
   input  wire logic                                   cpu_read_pending,
   input  wire logic                                   cpu_busy,
   // cpu write to the port data register
   input  wire logic                                   cpu_wr_valid,
   input  wire logic [dbg_serial_pkg::CPU_WORD_WIDTH-1:0] cpu_wr_data,
   // exception sources and their enables
   input  wire logic [dbg_serial_pkg::EXC_SOURCES-1:0] cpu_exc_events,
   input  wire logic [dbg_serial_pkg::EXC_SOURCES-1:0] debug_enable_mask,
   // words to the cpu and access termination
   output var  dbg_serial_pkg::cpu_word_type           cpu_word,
   output var  logic                                   cpu_bus_error,
   // trap enable control outputs
   output var  dbg_serial_pkg::trap_ctrl_type          trap_enable_control
);
   import dbg_serial_pkg::*;

   // refuse package geometry that the frame logic cannot serve
   if (CPU_FRAME_BITS != SHIFT_WIDTH) begin : g_frame_check
      $error("dbg_serial_port: a cpu frame must fill the whole shift register");
   end
   if ((1 << COUNT_WIDTH) <= CPU_FRAME_BITS) begin : g_count_check
      $error("dbg_serial_port: bit counter too narrow for a cpu frame");
   end
   if (TRAP_FRAME_BITS != TRAP_DATA_WIDTH + 3) begin : g_trap_check
      $error("dbg_serial_port: trap frame is start, length, control and data bits");
   end

   // synchronised pins
   logic [1:0]                 pins_sync;          // {clock, data}
   logic                       sclk_sync;          // synchronised serial clock
   logic                       sdin_sync;          // synchronised serial data
   logic                       sclk_prev_reg;      // serial clock one cycle ago
   logic                       sclk_rise;          // rising serial clock edge

   // frame machine
   state_type                  state_reg;          // current state
   state_type                  state_next;         // next state
   logic [SHIFT_WIDTH-1:0]     shift_reg;          // port shift register
   logic [SHIFT_WIDTH-1:0]     shift_next;         // next shift register
   logic [COUNT_WIDTH-1:0]     count_reg;          // bits taken in this frame
   logic [COUNT_WIDTH-1:0]     count_next;         // next bit count
   logic                       discard_reg;        // drop this frame's input
   logic                       discard_next;       // next discard flag

   // latches
   logic                       seq_latch_reg;      // sequencing error pending
   logic                       exc_latch_reg;      // cpu exception pending
   logic                       data_loaded_reg;    // cpu data waiting to go out
   logic [CPU_WORD_WIDTH-1:0]  data_word_reg;      // cpu data word

   // decode of the completed frame
   logic                       frame_is_trap;      // length bit set
   logic                       frame_ctrl;         // control bit
   logic                       frame_end;          // last bit shifted in
   logic                       cpu_frame_bad;      // cpu frame raises error
   logic                       deliver;            // word goes to the cpu
   logic                       exc_event;          // enabled exception seen
   logic                       seq_set;            // set the sequencing latch
   logic                       load_out;           // load next output frame
   status_type                 out_status;         // status of next frame
   logic [CPU_WORD_WIDTH-1:0]  out_data;           // data of next frame
   logic                       ready_ok;           // frame may be closed
   logic                       out_pin_next;       // next serial out level
   logic                       seq_out_load;       // sequencing status loaded now
   logic                       exc_out_load;       // exception status loaded now
   logic                       exc_set;            // set the exception latch

   // pin synchronisers
   sync_two_stage #(
      .WIDTH    (2)
   ) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({serial_clock_in, serial_data_in}),
      .sync_out (pins_sync)
   );

   // split synchronised pins
   assign sclk_sync = pins_sync[1];
   assign sdin_sync = pins_sync[0];

   // remember last serial clock level
   // reset low matches the idle pin, so no false edge follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_sync;
      end
   end

   assign sclk_rise = sclk_sync & ~sclk_prev_reg;

   assign frame_is_trap = (count_reg >= COUNT_WIDTH'(2)) &&
                          (count_reg == COUNT_WIDTH'(TRAP_FRAME_BITS) ?
                           shift_reg[TRAP_LEN_POS] : shift_reg[CPU_LEN_POS]);

   // frame end after the right number of bits
   // a trap frame ends on its tenth bit, a cpu frame on its last; the length bit decides
   assign frame_end = sclk_rise && (state_reg == ST_SHIFT) &&
                      ((count_reg == COUNT_WIDTH'(TRAP_FRAME_BITS - 1) && shift_reg[TRAP_LEN_POS - 1]) ||
                       (count_reg == COUNT_WIDTH'(CPU_FRAME_BITS - 1)));

   assign frame_ctrl = frame_is_trap ? shift_reg[TRAP_CTRL_POS] : shift_reg[CPU_CTRL_POS];

   assign cpu_frame_bad = !debug_mode ||
                          (!frame_ctrl && cpu_read_pending) ||
                          (frame_ctrl && cpu_fetch_pending && !cpu_read_pending);

   // completed cpu frame that is kept
   assign deliver = (state_reg == ST_DONE) && !discard_reg && !frame_is_trap && !cpu_frame_bad;

   // sequencing error from a kept cpu frame
   assign seq_set = (state_reg == ST_DONE) && !discard_reg && !frame_is_trap && cpu_frame_bad;

   assign exc_event = debug_mode && |(cpu_exc_events & debug_enable_mask);

   assign ready_ok = !debug_mode || !cpu_busy;

   // output frame is loaded when ready is raised
   assign load_out = (state_reg == ST_WAITCPU) && ready_ok;

   // status that is being loaded into the next output frame
   assign seq_out_load = load_out && (out_status == STATUS_SEQ_ERROR);
   assign exc_out_load = load_out && (out_status == STATUS_CPU_EXC);

   // follow-up exception, debug only
   // the bus error turns into a cpu exception whenever a sequencing status is loaded in debug mode;
   // outside debug a sequencing status is followed by null
   assign exc_set = exc_event || (seq_out_load && debug_mode);

   assign out_status = data_loaded_reg ? STATUS_VALID_DATA :
                       seq_latch_reg   ? STATUS_SEQ_ERROR  :
                       exc_latch_reg   ? STATUS_CPU_EXC    : STATUS_NULL;

   assign out_data = (out_status == STATUS_VALID_DATA) ? data_word_reg : {CPU_WORD_WIDTH{1'b1}};

   // frame state and shift register next values
   // bits that arrive while in done or waitcpu are ignored
   always_comb begin
      state_next   = state_reg;
      shift_next   = shift_reg;
      count_next   = count_reg;
      discard_next = discard_reg;
      unique case (state_reg)
         // ready bit showing, wait for start
         ST_READY: begin
            if (sclk_rise) begin
               shift_next = {shift_reg[SHIFT_WIDTH-2:0], sdin_sync};
               if (sdin_sync) begin
                  state_next = ST_SHIFT;
                  count_next = COUNT_WIDTH'(1);
               end else begin
                  shift_next = shift_reg;
               end
            end
         end
         // taking frame bits
         ST_SHIFT: begin
            if (sclk_rise) begin
               shift_next = {shift_reg[SHIFT_WIDTH-2:0], sdin_sync};
               count_next = count_reg + COUNT_WIDTH'(1);
               if (frame_end) begin
                  state_next = ST_DONE;
               end
            end
         end
         // act on the received frame
         ST_DONE: begin
            state_next = ST_WAITCPU;
         end
         // wait for cpu activity to finish
         ST_WAITCPU: begin
            if (ready_ok) begin
               state_next = ST_READY;
               count_next = '0;
               shift_next = {1'b0, out_status, out_data};
               discard_next = (out_status == STATUS_SEQ_ERROR) || (out_status == STATUS_CPU_EXC);
            end
         end
      endcase
   end

   // frame state registers
   // reset enters waitcpu so ready shows as soon as the cpu allows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ST_WAITCPU;
         shift_reg   <= SHIFT_RESET;
         count_reg   <= '0;
         discard_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         shift_reg   <= shift_next;
         count_reg   <= count_next;
         discard_reg <= discard_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_latch_reg <= 1'b0;
      end else if (seq_set) begin
         seq_latch_reg <= 1'b1;
      end else if (seq_out_load) begin
         seq_latch_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exc_latch_reg <= 1'b0;
      end else if (exc_set) begin
         // set wins over the clear in the same cycle
         exc_latch_reg <= 1'b1;
      end else if (exc_out_load) begin
         exc_latch_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_loaded_reg <= 1'b0;
         data_word_reg   <= '0;
      end else if (cpu_wr_valid && debug_mode) begin
         data_loaded_reg <= 1'b1;
         data_word_reg   <= cpu_wr_data;
      end else if (load_out) begin
         data_loaded_reg <= 1'b0;
      end
   end

   // handed over at end
   // word and type hold between pulses so a slow cpu can still take them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_word <= '0;
      end else begin
         cpu_word.valid   <= deliver;
         cpu_word.is_data <= deliver ? frame_ctrl : cpu_word.is_data;
         cpu_word.word    <= deliver ? shift_reg[CPU_WORD_WIDTH-1:0] : cpu_word.word;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_bus_error <= 1'b0;
      end else begin
         cpu_bus_error <= seq_set || exc_out_load;
      end
   end

   // breakpoint and trap frames
   // a discarded frame leaves the trap enables alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trap_enable_control <= {TRAP_RESET, 1'b0, 1'b0};
      end else if (state_reg == ST_DONE && !discard_reg && frame_is_trap) begin
         if (frame_ctrl) begin
            trap_enable_control.brk_nonmask <= shift_reg[BRK_NONMASK_POS];
            trap_enable_control.brk_mask    <= shift_reg[BRK_MASK_POS];
         end else begin
            trap_enable_control.trap_enables <= shift_reg[TRAP_DATA_WIDTH-1:0];
         end
      end
   end

   assign out_pin_next = (gp_out_enable && !debug_mode) ? gp_out_level : shift_reg[SHIFT_WIDTH-1];

   // registered serial output
   // high in reset, so the tool sees not ready until the first frame loads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_out <= 1'b1;
      end else begin
         serial_data_out <= out_pin_next;
      end
   end

endmodule : dbg_serial_port
`default_nettype wire

// File: verification/dbg_serial_props.sv
`timescale 1ns/1ns
`default_nettype none
module dbg_serial_props (
   // clock and reset
   input wire logic                          clk,
   input wire logic                          rst_n,
   // serial pins and general output
   input wire logic                          serial_clock_in,
   input wire logic                          serial_data_out,
   input wire logic                          gp_out_enable,
   input wire logic                          gp_out_level,
   // cpu side
   input wire logic                          debug_mode,
   input wire logic                          cpu_fetch_pending,
   input wire logic                          cpu_read_pending,
   input wire dbg_serial_pkg::cpu_word_type  cpu_word,
   input wire logic                          cpu_bus_error,
   input wire dbg_serial_pkg::trap_ctrl_type trap_enable_control
);
   import dbg_serial_pkg::*;
   // cycles since the serial clock pin was last seen high
   logic [5:0] idle_reg;
   logic [5:0] idle_next;
   assign idle_next = serial_clock_in ? 6'h00 : ((idle_reg == 6'h3F) ? idle_reg : idle_reg + 6'h01);
   // saturating idle counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= 6'h3F;
      end else begin
         idle_reg <= idle_next;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // general output selected and steady for three cycles
   sequence gp_held;
      (gp_out_enable && !debug_mode && $stable(gp_out_level)) [*3];
   endsequence
   gp_out_a: assert property (gp_held |-> serial_data_out == gp_out_level)
      else $error("serial out not following general output");
   word_at_end_a: assert property (cpu_word.valid |-> idle_reg <= 6'h08)
      else $error("cpu word handed over away from frame end");
   trap_at_end_a: assert property ($changed(trap_enable_control) |-> idle_reg <= 6'h08)
      else $error("trap control changed away from frame end");
   word_pulse_a: assert property (cpu_word.valid |=> !cpu_word.valid)
      else $error("cpu word valid longer than one cycle");
   err_pulse_a: assert property (cpu_bus_error |=> !cpu_bus_error)
      else $error("bus error longer than one cycle");
   word_debug_a: assert property (cpu_word.valid |-> debug_mode)
      else $error("cpu word outside debug mode");
   word_no_err_a: assert property (cpu_word.valid |-> !cpu_bus_error)
      else $error("cpu word together with bus error");
   type_match_a: assert property (cpu_word.valid |-> cpu_word.is_data == cpu_read_pending)
      else $error("cpu word type differs from pending access");
endmodule : dbg_serial_props
bind dbg_serial_port dbg_serial_props props (
   .clk(clk), .rst_n(rst_n), .serial_clock_in(serial_clock_in), .serial_data_out(serial_data_out),
   .gp_out_enable(gp_out_enable), .gp_out_level(gp_out_level), .debug_mode(debug_mode),
   .cpu_fetch_pending(cpu_fetch_pending), .cpu_read_pending(cpu_read_pending), .cpu_word(cpu_word),
   .cpu_bus_error(cpu_bus_error), .trap_enable_control(trap_enable_control)
);
`default_nettype wire

// File: verification/dev_tool.sv
`timescale 1ns/1ns
`default_nettype none
module dev_tool (
   // system clock used for pacing
   input  wire logic clk,
   // serial lines
   input  wire logic serial_data_out,
   output var  logic serial_clock_in,
   output var  logic serial_data_in
);
   // clock stands low and data low (no start) between frames
   initial begin
      serial_clock_in = 1'b0;
      serial_data_in  = 1'b0;
   end
   // one frame msb first from frame[nb-1:0]; got holds the bits seen on the output
   task automatic xfer(input int nb, input logic [34:0] frame, output logic [34:0] got, output logic to);
      int w;
      got = '0;
      w = 0;
      repeat (4) @(posedge clk);
      while (serial_data_out !== 1'b0 && w < 2000) begin
         @(posedge clk);
         w++;
      end
      to = (w >= 2000);
      // whole frame
      // one bit per 12 system clocks: data changes with the falling serial clock
      for (int i = nb - 1; i >= 0; i--) begin
         serial_data_in <= frame[i];
         repeat (6) @(posedge clk);
         got[i] = serial_data_out;
         serial_clock_in <= 1'b1;
         repeat (6) @(posedge clk);
         serial_clock_in <= 1'b0;
      end
      @(posedge clk);
      serial_data_in <= 1'b0;
   endtask : xfer
endmodule : dev_tool
`default_nettype wire

// File: verification/debug_port_serial_protocol_test.sv
`timescale 1ns/1ns
`default_nettype none
module debug_port_serial_protocol_test;
   import dbg_serial_pkg::*;
   // design inputs
   logic          clk, rst_n, sclk, sdi, gp_en, gp_lvl, dbg, fetch, rd, busy, wr_v;
   logic [31:0]   wr_d;
   logic [2:0]    exc, mask;
   // design outputs
   logic          sdo, berr;
   cpu_word_type  cw, last_word;
   trap_ctrl_type tec;
   // bookkeeping
   int            n_errors, n_tests;
   int            n_words = 0;
   int            n_berr = 0;

   dbg_serial_port DUT (
      .clk(clk), .rst_n(rst_n), .serial_clock_in(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
      .gp_out_enable(gp_en), .gp_out_level(gp_lvl), .debug_mode(dbg), .cpu_fetch_pending(fetch),
      .cpu_read_pending(rd), .cpu_busy(busy), .cpu_wr_valid(wr_v), .cpu_wr_data(wr_d),
      .cpu_exc_events(exc), .debug_enable_mask(mask), .cpu_word(cw), .cpu_bus_error(berr),
      .trap_enable_control(tec)
   );
   dev_tool tool (.clk(clk), .serial_data_out(sdo), .serial_clock_in(sclk), .serial_data_in(sdi));

   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // count word and bus error pulses
   always @(posedge clk) begin
      if (cw.valid === 1'b1) begin
         n_words++;
         last_word = cw;
      end
      if (berr === 1'b1) begin
         n_berr++;
      end
   end
   // frame builders
   function automatic logic [34:0] cpu_f(input logic c, input logic [31:0] w);
      return {1'b1, 1'b0, c, w};
   endfunction : cpu_f
   function automatic logic [34:0] trap_f(input logic c, input logic [6:0] d);
      return {25'h0, 1'b1, 1'b1, c, d};
   endfunction : trap_f
   task automatic print_verdict;
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp_val(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_status(input int nb, input logic [34:0] got, input logic [1:0] st, input logic [31:0] dat);
      logic [34:0] exp;
      exp = '0;
      exp[nb-2 -: 2] = st;
      if (nb == 35) begin
         exp[31:0] = dat;
      end else begin
         exp[6:0] = dat[31:25];
      end
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t frame out %h expected %h", $time, got, exp);
      end
   endtask : cmp_status
   task automatic frame(input int nb, input logic [34:0] f, input logic [1:0] st, input logic [31:0] dat);
      logic [34:0] got;
      logic        to;
      tool.xfer(nb, f, got, to);
      cmp_val({33'h0, to}, 34'h0);
      cmp_status(nb, got, st, dat);
   endtask : frame
   // cpu write, exception pulse and mask, then cpu done
   task automatic cpu_act(input logic wv, input logic [31:0] wd, input logic [2:0] e, input logic [2:0] m);
      @(posedge clk);
      wr_v <= wv;
      wr_d <= wd;
      exc  <= e;
      mask <= m;
      @(posedge clk);
      wr_v <= 1'b0;
      exc  <= 3'h0;
      busy <= 1'b0;
   endtask : cpu_act
   // watchdog
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      $display("CHECK FAILED %0t watchdog", $time);
      print_verdict();
   end
   initial begin
      logic [31:0] w, v;
      logic [6:0]  d;
      logic [2:0]  e;
      int          nw, nb, seed;
      {rst_n, gp_en, gp_lvl, dbg, fetch, rd, busy, wr_v} = 8'h00;
      wr_d = 32'h0;
      exc = 3'h0;
      mask = 3'h0;
      n_errors = 0;
      n_tests = 0;
      seed = $urandom(30528);
      repeat (8) @(posedge clk);
      cmp_val({24'h0, sdo, tec}, {24'h0, 1'b1, 9'h000});
      rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         d = 7'($urandom);
         frame(10, trap_f(1'b0, d), STATUS_NULL, 32'hFFFFFFFF);
         frame(10, trap_f(1'b1, {k[1:0], 5'h1F}), STATUS_NULL, 32'hFFFFFFFF);
         cmp_val({25'h0, tec}, {25'h0, d, k[1:0]});
      end
      nb = n_berr;
      nw = n_words;
      frame(35, cpu_f(1'b0, 32'($urandom)), STATUS_NULL, 32'hFFFFFFFF);
      frame(10, trap_f(1'b0, ~d), STATUS_SEQ_ERROR, 32'hFFFFFFFF);
      cmp_val({25'h0, tec}, {25'h0, d, 2'b11});
      cmp_val({17'(n_berr - nb), 17'(n_words - nw)}, {17'h1, 17'h0});
      frame(10, trap_f(1'b0, d), STATUS_NULL, 32'hFFFFFFFF);
      dbg <= 1'b1;
      fetch <= 1'b1;
      busy <= 1'b1;
      w = $urandom;
      v = $urandom;
      frame(35, cpu_f(1'b0, w), STATUS_NULL, 32'hFFFFFFFF);
      cmp_val(last_word, {2'b10, w});
      cpu_act(1'b1, v, 3'b001, 3'b001);
      nb = n_berr;
      nw = n_words;
      frame(35, cpu_f(1'b0, w), STATUS_VALID_DATA, v);
      frame(35, cpu_f(1'b0, ~w), STATUS_CPU_EXC, 32'hFFFFFFFF);
      cmp_val({17'(n_berr - nb), 17'(n_words - nw)}, {17'h1, 17'h1});
      e = 3'($urandom);
      cpu_act(1'b0, 32'h0, e, ~e);
      frame(35, cpu_f(1'b0, w), STATUS_NULL, 32'hFFFFFFFF);
      for (int c = 0; c < 2; c++) begin
         rd <= c[0];
         nb = n_berr;
         nw = n_words;
         frame(35, cpu_f(~c[0], w), STATUS_NULL, 32'hFFFFFFFF);
         frame(35, cpu_f(1'b0, w), STATUS_SEQ_ERROR, 32'hFFFFFFFF);
         frame(35, cpu_f(1'b0, w), STATUS_CPU_EXC, 32'hFFFFFFFF);
         cmp_val({17'(n_berr - nb), 17'(n_words - nw)}, {17'h2, 17'h0});
         rd <= 1'b0;
         frame(35, cpu_f(1'b0, v), STATUS_NULL, 32'hFFFFFFFF);
         cmp_val(last_word, {2'b10, v});
      end
      dbg <= 1'b0;
      gp_en <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         gp_lvl <= 1'($urandom);
         repeat (4) @(posedge clk);
         cmp_val({33'h0, sdo}, {33'h0, gp_lvl});
      end
      print_verdict();
   end
endmodule : debug_port_serial_protocol_test
`default_nettype wire
